// ---- rtl/lofs_pkg.sv ----
// Constants and types of the line and over-voltage fault supervisor
// Function
// - Four test pulses per lockout cycle, first ignored
// - Three low line pulses stop and drop bias
// - Line above brown-in starts soft start
// - Brown-out needs more than 60 ms low plus 3 pulses
// - Halted switching keeps brown-out pending, no shutdown
// - Supply off level clears brown-out fault
// - Low sample starts timer, high sample clears it
// - Verify pulses confirm or cancel pending brown-out
// - Three over-voltage pulses stop, start 1.5 s delay
// - Recovery delay: lockout cycling only, no test pulses
// - Restart after delay and next supply off
// - Fault-sense above 4.5 V for 750 us faults
// - Input over-voltage ends switching, restarts lockout
// - Check fault-sense at supply on before switching
// - Input over-voltage clears below 4.43 V
// - Bias source off above 2.5 V
package lofs_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned US_PER_S   = 1_000_000;
  localparam logic [5:0]  US_CYCLES  = 6'(CLK_HZ / US_PER_S);
  localparam logic [9:0]  MS_US      = 10'h3e8;

  // Timer figures in their own units and derived tick counts
  localparam int unsigned BO_TIME_MS   = 60;
  localparam logic [5:0]  BO_TICKS     = 6'(BO_TIME_MS);
  localparam real         FDR_TIME_S   = 1.5;
  localparam logic [10:0] FDR_TICKS    = 11'($rtoi(FDR_TIME_S * 1000.0));
  localparam int unsigned INPUT_OVERVOLTAGE_FAULT_TIME_US = 750;
  localparam logic [9:0]  INPUT_OVERVOLTAGE_FAULT_TICKS   = 10'(INPUT_OVERVOLTAGE_FAULT_TIME_US);

  // Pulse qualifier counts
  localparam logic [2:0] BI_TEST_PULSES = 3'h4;
  localparam logic [1:0] BI_LOW_PULSES  = 2'h3;
  localparam logic [1:0] BO_VERIFY      = 2'h3;
  localparam logic [1:0] OVP_PULSES     = 2'h3;

  // Comparator results from the analog front end
  typedef struct packed {
    logic line_run_ok;   // Line current above brown-in level
    logic line_stop_ok;  // Line current above brown-out level
    logic aux_ovp;       // Aux sense at or above output OV level
    logic flt_input_overvoltage_fault;      // Fault sense above 4.5 V
    logic flt_input_overvoltage_fault_rel;  // Fault sense below 4.43 V
    logic flt_bias_hi;   // Fault sense above 2.5 V
  } lofs_sense_t;

  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_CHECK,
    ST_TEST,
    ST_RUN,
    ST_HALT,
    ST_FDR
  } lofs_state_t;

endpackage

// ---- rtl/lofs_supervisor.sv ----
// Line brown-in/out and over-voltage fault supervisor
module lofs_supervisor (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   supply_on_in,
  input  wire logic                   supply_off_in,
  input  wire logic                   low_side_gate_pulse_in,
  input  wire lofs_pkg::lofs_sense_t  sense_in,
  output logic                        gate_enable_out,
  output logic                        test_pulse_out,
  output logic                        soft_start_out,
  output logic                        bias_active_out,
  output logic                        brown_out_fault_out,
  output logic                        output_overvoltage_fault_out,
  output logic                        input_overvoltage_fault_out,
  output logic                        fault_bias_en_out,
  output lofs_pkg::lofs_state_t       state_out
);

  localparam int SYNC_W = $bits(lofs_pkg::lofs_sense_t) + 3;

  logic [SYNC_W-1:0]     sync1_q;
  logic [SYNC_W-1:0]     sync2_q;
  logic                  gate_prev_q;
  logic                  off_prev_q;
  lofs_pkg::lofs_sense_t sense_s;
  logic                  on_s;
  logic                  off_s;
  logic                  gate_s;
  logic                  sample_ev;
  logic                  off_rise;
  logic [5:0]            us_cnt_q;
  logic [9:0]            ms_cnt_q;
  logic                  us_tick_q;
  logic                  ms_tick_q;
  lofs_pkg::lofs_state_t state_q;
  lofs_pkg::lofs_state_t state_d;
  logic [2:0]            bi_cnt_q;
  logic [1:0]            bi_low_q;
  logic [1:0]            ovp_cnt_q;
  logic                  bo_run_q;
  logic [5:0]            bo_cnt_q;
  logic [1:0]            bo_ver_q;
  logic                  bo_pend;
  logic [10:0]           fdr_cnt_q;
  logic                  fdr_done;
  logic [9:0]            input_overvoltage_fault_cnt_q;
  logic                  input_overvoltage_fault_set;
  logic                  bi_pass;
  logic                  bi_fail;
  logic                  ovp_trip;
  logic                  bo_trip;
  logic                  gate_en_q;
  logic                  test_q;
  logic                  ss_q;
  logic                  bias_q;
  logic                  bo_fault_q;
  logic                  ovp_fault_q;
  logic                  input_overvoltage_fault_fault_q;
  logic                  fbias_q;

  // Two-flop synchronisers for all analog and pin levels
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      gate_prev_q <= 1'b0;
      off_prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q     <= {sense_in, supply_on_in, supply_off_in, low_side_gate_pulse_in};
      sync2_q     <= sync1_q;
      gate_prev_q <= gate_s;
      off_prev_q  <= off_s;
    end
  end

  // Synchronised fields and edge events
  assign sense_s   = lofs_pkg::lofs_sense_t'(sync2_q[SYNC_W-1:3]);
  assign on_s      = sync2_q[2];
  assign off_s     = sync2_q[1];
  assign gate_s    = sync2_q[0];
  assign sample_ev = gate_prev_q & ~gate_s;
  assign off_rise  = off_s & ~off_prev_q;

  // Microsecond and millisecond reference ticks
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      us_cnt_q  <= 6'h00;
      ms_cnt_q  <= 10'h000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end
    else
    begin
      us_tick_q <= (us_cnt_q == lofs_pkg::US_CYCLES - 6'h01);
      us_cnt_q  <= (us_cnt_q == lofs_pkg::US_CYCLES - 6'h01) ? 6'h00 : us_cnt_q + 6'h01;
      ms_tick_q <= us_tick_q && (ms_cnt_q == lofs_pkg::MS_US - 10'h001);
      if (us_tick_q)
      begin
        ms_cnt_q <= (ms_cnt_q == lofs_pkg::MS_US - 10'h001) ? 10'h000 : ms_cnt_q + 10'h001;
      end
    end
  end

  // Qualifier decisions
  assign bo_pend  = bo_cnt_q > lofs_pkg::BO_TICKS;
  assign fdr_done = fdr_cnt_q >= lofs_pkg::FDR_TICKS;
  assign input_overvoltage_fault_set = us_tick_q && sense_s.flt_input_overvoltage_fault && (input_overvoltage_fault_cnt_q == lofs_pkg::INPUT_OVERVOLTAGE_FAULT_TICKS);
  assign ovp_trip = sample_ev && sense_s.aux_ovp && (ovp_cnt_q == lofs_pkg::OVP_PULSES - 2'h1)
                    && (state_q == lofs_pkg::ST_TEST || state_q == lofs_pkg::ST_RUN);
  assign bi_pass  = (state_q == lofs_pkg::ST_TEST) && sample_ev && (bi_cnt_q != 3'h0)
                    && sense_s.line_run_ok;
  assign bi_fail  = (state_q == lofs_pkg::ST_TEST) && sample_ev && (bi_cnt_q != 3'h0)
                    && !sense_s.line_run_ok && (bi_low_q == lofs_pkg::BI_LOW_PULSES - 2'h1);
  assign bo_trip  = (state_q == lofs_pkg::ST_RUN) && sample_ev && !sense_s.line_stop_ok
                    && bo_pend && (bo_ver_q == lofs_pkg::BO_VERIFY - 2'h1);

  // Next sequencer state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lofs_pkg::ST_LOCKOUT:
        if (on_s) state_d = lofs_pkg::ST_CHECK;
      lofs_pkg::ST_CHECK:
        if (off_s) state_d = lofs_pkg::ST_LOCKOUT;
        else if (input_overvoltage_fault_fault_q) state_d = lofs_pkg::ST_HALT;
        else if (!sense_s.flt_input_overvoltage_fault) state_d = lofs_pkg::ST_TEST;
      lofs_pkg::ST_TEST:
        if (off_s) state_d = lofs_pkg::ST_LOCKOUT;
        else if (input_overvoltage_fault_set) state_d = lofs_pkg::ST_HALT;
        else if (ovp_trip) state_d = lofs_pkg::ST_FDR;
        else if (bi_fail) state_d = lofs_pkg::ST_HALT;
        else if (bi_pass) state_d = lofs_pkg::ST_RUN;
      lofs_pkg::ST_RUN:
        if (off_s) state_d = lofs_pkg::ST_LOCKOUT;
        else if (input_overvoltage_fault_set) state_d = lofs_pkg::ST_HALT;
        else if (ovp_trip) state_d = lofs_pkg::ST_FDR;
        else if (bo_trip) state_d = lofs_pkg::ST_HALT;
      lofs_pkg::ST_HALT:
        if (off_s) state_d = lofs_pkg::ST_LOCKOUT;
      lofs_pkg::ST_FDR:
        if (fdr_done && off_rise) state_d = lofs_pkg::ST_LOCKOUT;
      default:
        state_d = lofs_pkg::ST_LOCKOUT;
    endcase
  end

  // Sequencer state and registered outputs
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q   <= lofs_pkg::ST_LOCKOUT;
      gate_en_q <= 1'b0;
      test_q    <= 1'b0;
      ss_q      <= 1'b0;
      bias_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      gate_en_q <= (state_d == lofs_pkg::ST_TEST) || (state_d == lofs_pkg::ST_RUN);
      test_q    <= (state_d == lofs_pkg::ST_TEST);
      ss_q      <= (state_q == lofs_pkg::ST_TEST) && (state_d == lofs_pkg::ST_RUN);
      bias_q    <= (state_d == lofs_pkg::ST_RUN);
    end
  end

  // Brown-in test pulse counting, first result discarded
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bi_cnt_q <= 3'h0;
      bi_low_q <= 2'h0;
    end
    else if (state_q != lofs_pkg::ST_TEST)
    begin
      bi_cnt_q <= 3'h0;
      bi_low_q <= 2'h0;
    end
    else if (sample_ev)
    begin
      if (bi_cnt_q != lofs_pkg::BI_TEST_PULSES)
        bi_cnt_q <= bi_cnt_q + 3'h1;
      if (bi_cnt_q != 3'h0)
        bi_low_q <= sense_s.line_run_ok ? 2'h0 : bi_low_q + 2'h1;
    end
  end

  // Output over-voltage consecutive pulse qualifier
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ovp_cnt_q <= 2'h0;
    else if (state_q != lofs_pkg::ST_TEST && state_q != lofs_pkg::ST_RUN)
      ovp_cnt_q <= 2'h0;
    else if (sample_ev)
      ovp_cnt_q <= sense_s.aux_ovp ? ovp_cnt_q + 2'h1 : 2'h0;
  end

  // Brown-out timer and verification counter
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bo_run_q <= 1'b0;
      bo_cnt_q <= 6'h00;
      bo_ver_q <= 2'h0;
    end
    else if (state_q == lofs_pkg::ST_LOCKOUT)
    begin
      bo_run_q <= 1'b0;
      bo_cnt_q <= 6'h00;
      bo_ver_q <= 2'h0;
    end
    else if (state_q == lofs_pkg::ST_RUN && sample_ev && sense_s.line_stop_ok)
    begin
      bo_run_q <= 1'b0;
      bo_cnt_q <= 6'h00;
      bo_ver_q <= 2'h0;
    end
    else
    begin
      if (state_q == lofs_pkg::ST_RUN && sample_ev)
        bo_run_q <= 1'b1;
      if (bo_run_q && ms_tick_q && !bo_pend)
        bo_cnt_q <= bo_cnt_q + 6'h01;
      if (state_q == lofs_pkg::ST_RUN && sample_ev && bo_pend)
        bo_ver_q <= bo_ver_q + 2'h1;
    end
  end

  // Fault recovery delay, counted only in its own state
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      fdr_cnt_q <= 11'h000;
    else if (state_q != lofs_pkg::ST_FDR)
      fdr_cnt_q <= 11'h000;
    else if (ms_tick_q && !fdr_done)
      fdr_cnt_q <= fdr_cnt_q + 11'h001;
  end

  // Input over-voltage continuous filter
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      input_overvoltage_fault_cnt_q <= 10'h000;
    else if (!sense_s.flt_input_overvoltage_fault || state_q == lofs_pkg::ST_LOCKOUT)
      input_overvoltage_fault_cnt_q <= 10'h000;
    else if (us_tick_q && input_overvoltage_fault_cnt_q != lofs_pkg::INPUT_OVERVOLTAGE_FAULT_TICKS)
      input_overvoltage_fault_cnt_q <= input_overvoltage_fault_cnt_q + 10'h001;
  end

  // Fault flags; a set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bo_fault_q   <= 1'b0;
      ovp_fault_q  <= 1'b0;
      input_overvoltage_fault_fault_q <= 1'b0;
      fbias_q      <= 1'b1;
    end
    else
    begin
      if (bo_trip)
        bo_fault_q <= 1'b1;
      else if (off_s)
        bo_fault_q <= 1'b0;
      if (ovp_trip)
        ovp_fault_q <= 1'b1;
      else if (state_q != lofs_pkg::ST_FDR)
        ovp_fault_q <= 1'b0;
      if (input_overvoltage_fault_set)
        input_overvoltage_fault_fault_q <= 1'b1;
      else if (sense_s.flt_input_overvoltage_fault_rel)
        input_overvoltage_fault_fault_q <= 1'b0;
      fbias_q <= !sense_s.flt_bias_hi;
    end
  end

  assign gate_enable_out              = gate_en_q;
  assign test_pulse_out               = test_q;
  assign soft_start_out               = ss_q;
  assign bias_active_out              = bias_q;
  assign brown_out_fault_out          = bo_fault_q;
  assign output_overvoltage_fault_out = ovp_fault_q;
  assign input_overvoltage_fault_out  = input_overvoltage_fault_fault_q;
  assign fault_bias_en_out            = fbias_q;
  assign state_out                    = state_q;

  // Checks on the sequencer and qualifiers
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_first_ignored: assert property (
    (state_q == lofs_pkg::ST_TEST && sample_ev && bi_cnt_q == 3'h0 && !off_s && !input_overvoltage_fault_set)
    |=> state_q == lofs_pkg::ST_TEST)
    else $error("first test pulse was not ignored");
  chk_brownin_fail: assert property (
    (bi_fail && !off_s && !input_overvoltage_fault_set && !ovp_trip)
    |=> state_q == lofs_pkg::ST_HALT ##1 !gate_enable_out && !bias_active_out)
    else $error("brown-in failure did not halt");
  chk_brownin_pass: assert property (
    (bi_pass && !off_s && !input_overvoltage_fault_set && !ovp_trip)
    |=> state_q == lofs_pkg::ST_RUN && soft_start_out && bias_active_out)
    else $error("brown-in pass did not start soft start");
  chk_bo_cause: assert property (
    $rose(bo_fault_q) |-> $past(bo_pend) && $past(bo_ver_q) == 2'h2)
    else $error("brown-out fault without timer and verify");
  chk_bo_clear: assert property (
    (state_q == lofs_pkg::ST_RUN && sample_ev && sense_s.line_stop_ok && !off_s)
    |=> bo_cnt_q == 6'h00 && !bo_run_q)
    else $error("brown-out timer not cleared");
  chk_ovp_stop: assert property (
    (ovp_trip && !off_s && !input_overvoltage_fault_set)
    |=> state_q == lofs_pkg::ST_FDR ##1 !gate_enable_out && !bias_active_out)
    else $error("over-voltage did not stop switching");
  chk_fdr_quiet: assert property (
    (state_q == lofs_pkg::ST_FDR)[*2] |-> !test_pulse_out && !gate_enable_out)
    else $error("pulses during recovery delay");
  chk_fdr_exit: assert property (
    $fell(state_q == lofs_pkg::ST_FDR)
    |-> $past(fdr_cnt_q) == lofs_pkg::FDR_TICKS && $past(off_s))
    else $error("recovery delay left early");
  chk_input_overvoltage_fault_stop: assert property (
    (input_overvoltage_fault_set && state_q == lofs_pkg::ST_RUN && !off_s)
    |=> state_q == lofs_pkg::ST_HALT ##1 !gate_enable_out && input_overvoltage_fault_out)
    else $error("input over-voltage did not end switching");
  chk_bias_src: assert property (
    sense_s.flt_bias_hi |=> !fault_bias_en_out)
    else $error("fault bias source left on");

  cov_brownin_pass: cover property (bi_pass);
  cov_brownin_fail: cover property (bi_fail);
  cov_bo_cancel: cover property (bo_pend && sample_ev && sense_s.line_stop_ok);
  cov_ovp_trip: cover property (ovp_trip);
  cov_input_overvoltage_fault_set: cover property (input_overvoltage_fault_set);

endmodule

// ---- verification/lofs_stage_model.sv ----
// Behavioural flyback stage that answers gate enable with low-side gate pulses
module lofs_stage_model (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic gate_enable_in,
  output logic      low_side_gate_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] phase_q;

  // Period of 20 clocks, on-time 8; gate driver idles low when switching stops
  always @(negedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in || !gate_enable_in)
    begin
      phase_q <= 5'h00;
      low_side_gate_pulse_out <= 1'b0;
    end
    else
    begin
      phase_q <= (phase_q == 5'h13) ? 5'h00 : phase_q + 5'h01;
      low_side_gate_pulse_out <= (phase_q >= 5'h04) && (phase_q < 5'h0c);
    end
  end
endmodule

// ---- verification/lofs_supervisor_bench.sv ----
// Self-checking bench of the line and over-voltage fault supervisor
module lofs_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic                  supply_on_in = 1'b0;
  logic                  supply_off_in = 1'b0;
  logic                  pulse;
  lofs_pkg::lofs_sense_t sense_in = '0;
  logic                  gate_en, test_p, soft_st, bias, bo_f, ovp_f, input_overvoltage_fault_f, fbias;
  lofs_pkg::lofs_state_t state_out;
  int                    failures = 0;
  int                    comparisons = 0;
  int                    seed = 18894;
  int                    us_clk;
  logic                  b;

  // Clock generation at 40 MHz
  always #12.5 clk_in = ~clk_in;

  lofs_supervisor u_lofs_supervisor (
    .clk_in                       (clk_in),
    .rst_n_in                     (rst_n_in),
    .supply_on_in                 (supply_on_in),
    .supply_off_in                (supply_off_in),
    .low_side_gate_pulse_in       (pulse),
    .sense_in                     (sense_in),
    .gate_enable_out              (gate_en),
    .test_pulse_out               (test_p),
    .soft_start_out               (soft_st),
    .bias_active_out              (bias),
    .brown_out_fault_out          (bo_f),
    .output_overvoltage_fault_out (ovp_f),
    .input_overvoltage_fault_out  (input_overvoltage_fault_f),
    .fault_bias_en_out            (fbias),
    .state_out                    (state_out)
  );

  lofs_stage_model u_lofs_stage_model (
    .clk_in                  (clk_in),
    .rst_n_in                (rst_n_in),
    .gate_enable_in          (gate_en),
    .low_side_gate_pulse_out (pulse)
  );

  // Comparison with mismatch report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected state encoding as compare width
  function automatic logic [7:0] st(input lofs_pkg::lofs_state_t s);
    return 8'(s);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Wait for n sample points, then let sync and state update settle
  task automatic pulses(input int n);
    repeat (n) @(negedge pulse);
    cyc(6);
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    cyc(3);
    rst_n_in = 1'b1;
    cyc(1);
  endtask

  task automatic strobe_off();
    supply_off_in = 1'b1;
    cyc(6);
    supply_off_in = 1'b0;
    cyc(2);
  endtask

  task automatic start();
    supply_on_in = 1'b1;
    cyc(6);
    supply_on_in = 1'b0;
    cyc(2);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 31k cycles
  initial
  begin
    repeat (60000) @(posedge clk_in);
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    us_clk = int'(lofs_pkg::US_CYCLES);
    do_reset();
    chk("reset state", st(lofs_pkg::ST_LOCKOUT), 8'(state_out));
    chk("reset outs", 8'h01, {1'b0, gate_en, test_p, soft_st, bias, bo_f, ovp_f | input_overvoltage_fault_f, fbias});
    $display("test reset done");
    // Brown-in failing: first sample ignored, three lows halt
    start();
    chk("test phase", 8'h03, {6'h00, gate_en, test_p});
    pulses(3);
    chk("after 3 low", st(lofs_pkg::ST_TEST), 8'(state_out));
    pulses(1);
    chk("after 4 low", st(lofs_pkg::ST_HALT), 8'(state_out));
    chk("halt outs", 8'h00, {6'h00, gate_en, bias});
    strobe_off();
    chk("off level", st(lofs_pkg::ST_LOCKOUT), 8'(state_out));
    $display("test brown_in_fail done");
    // Brown-in passing on second sample, one soft-start pulse
    sense_in.line_run_ok = 1'b1;
    sense_in.line_stop_ok = 1'b1;
    start();
    pulses(1);
    chk("first ignored", st(lofs_pkg::ST_TEST), 8'(state_out));
    @(negedge pulse);
    b = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      if (soft_st === 1'b1) chk("soft width", 8'h00, {7'h00, b});
      if (soft_st === 1'b1) b = 1'b1;
    end
    chk("soft seen", 8'h01, {7'h00, b});
    chk("run outs", 8'h03, {6'h00, gate_en, bias});
    $display("test brown_in_pass done");
    // Output over-voltage: broken run of two, then three in a row
    sense_in.aux_ovp = 1'b1;
    pulses(2);
    sense_in.aux_ovp = 1'b0;
    pulses(1);
    sense_in.aux_ovp = 1'b1;
    pulses(2);
    chk("ovp broken run", st(lofs_pkg::ST_RUN), 8'(state_out));
    pulses(1);
    sense_in.aux_ovp = 1'b0;
    chk("ovp trip", st(lofs_pkg::ST_FDR), 8'(state_out));
    chk("ovp outs", 8'h01, {5'h00, gate_en, bias, ovp_f});
    strobe_off();
    start();
    cyc(40);
    chk("fdr hold", st(lofs_pkg::ST_FDR), 8'(state_out));
    chk("fdr no test", 8'h00, {6'h00, gate_en, test_p});
    do_reset();
    $display("test output_ovp done");
    // Input over-voltage filter, restart check and release
    start();
    pulses(2);
    sense_in.flt_input_overvoltage_fault = 1'b1;
    sense_in.flt_bias_hi = 1'b1;
    sense_in.line_stop_ok = 1'b0;
    cyc((int'(lofs_pkg::INPUT_OVERVOLTAGE_FAULT_TICKS) - 10) * us_clk);
    chk("input_overvoltage_fault early", 8'h01, {6'h00, input_overvoltage_fault_f, gate_en});
    chk("bo early", 8'h00, {7'h00, bo_f});
    chk("bias src off", 8'h00, {7'h00, fbias});
    cyc(20 * us_clk);
    chk("input_overvoltage_fault late", 8'h02, {6'h00, input_overvoltage_fault_f, gate_en});
    chk("input_overvoltage_fault stop", st(lofs_pkg::ST_HALT), 8'(state_out));
    strobe_off();
    chk("input_overvoltage_fault lockout", st(lofs_pkg::ST_LOCKOUT), 8'(state_out));
    start();
    cyc(20);
    chk("check blocks", 8'h00, {7'h00, gate_en});
    sense_in.flt_input_overvoltage_fault = 1'b0;
    cyc(10);
    chk("input_overvoltage_fault hyst", 8'h01, {7'h00, input_overvoltage_fault_f});
    sense_in.flt_input_overvoltage_fault_rel = 1'b1;
    cyc(10);
    chk("input_overvoltage_fault clear", 8'h00, {7'h00, input_overvoltage_fault_f});
    $display("test input_ovp done");
    // Random fault-sense levels against bias source enable
    for (int i = 0; i < 12; i++)
    begin
      b = 1'($random(seed));
      sense_in.flt_bias_hi = b;
      sense_in.line_stop_ok = 1'($random(seed));
      cyc(5);
      chk("bias enable", {7'h00, ~b}, {7'h00, fbias});
    end
    $display("test bias_source done");
    tally_and_finish();
  end
endmodule
